// ===== src/rtp_pkg.sv
// rtp_pkg: constants and carriers for the regulator two-wire target port
// assumes a 100 MHz system clock; bus lines are sampled, never used as clocks
package rtp_pkg;
	localparam logic [6:0] RTP_TARGET_ADDR  = 7'h50;
	localparam logic [7:0] RTP_PTR_RESET    = 8'h00;
	localparam logic [3:0] RTP_BIT_LAST     = 4'h7;
	localparam logic [3:0] RTP_BIT_RESET    = 4'h0;
	localparam logic [4:0] RTP_HS_CODE_TOP  = 5'h01;
	localparam logic [6:0] RTP_GCALL_ADDR   = 7'h00;
	localparam int         RTP_SPIKE_NS     = 50;
	localparam int         RTP_SPIKE_HS_NS  = 10;
	localparam int         RTP_CLK_MHZ      = 100;
	localparam logic [2:0] RTP_FILT_LS      = 3'((RTP_SPIKE_NS * RTP_CLK_MHZ) / 1000);
	localparam logic [2:0] RTP_FILT_HS      = 3'((RTP_SPIKE_HS_NS * RTP_CLK_MHZ + 999) / 1000);
	localparam logic [1:0] RTP_FIFO_DEPTH   = 2'h2;

	typedef enum logic [2:0] {
		RTP_IDLE,
		RTP_ADDR,
		RTP_ACK_OUT,
		RTP_RX,
		RTP_TX,
		RTP_ACK_IN
	} rtp_state_e;

	// one register access leaving the port
	typedef struct packed {
		logic       is_write;
		logic [7:0] addr;
		logic [7:0] data;
	} rtp_req_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} rtp_pins_s;
endpackage

// ===== src/rtp_target.sv
// rtp_target: two-wire target port, byte engine and register access outlet
// assumes a register store that answers reads with data on the next cycle
`timescale 1ns/1ns
module rtp_target
#(
	parameter logic [6:0] TARGET_ADDR = rtp_pkg::RTP_TARGET_ADDR,
	parameter logic [2:0] FILT_LS_LEN = rtp_pkg::RTP_FILT_LS,
	parameter logic [2:0] FILT_HS_LEN = rtp_pkg::RTP_FILT_HS
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst,
	// bus pins
	input  wire logic             i_scl,
	input  wire logic             i_sda,
	output logic                  o_sda_out,
	output logic                  o_sda_oe,
	output logic                  o_scl_out,
	output logic                  o_scl_oe,
	// register access outlet
	output rtp_pkg::rtp_req_s     o_req,
	output logic                  o_req_valid,
	input  wire logic             i_req_ready,
	input  wire logic [7:0]       i_rd_data,
	// status
	output logic                  o_hs_mode,
	output logic                  o_busy
);
	import rtp_pkg::*;

	// refuse settings the decoder cannot serve
	if (TARGET_ADDR == RTP_GCALL_ADDR) begin : g_bad_gcall
		$error("target address may not be the general call address");
	end
	if (TARGET_ADDR[6:2] == RTP_HS_CODE_TOP) begin : g_bad_hs
		$error("target address collides with the high-speed code");
	end
	if (FILT_HS_LEN == 3'h0 || FILT_LS_LEN < FILT_HS_LEN) begin : g_bad_filt
		$error("spike filter lengths out of range");
	end

	typedef struct packed {
		rtp_pins_s  sync1;
		rtp_pins_s  sync2;
		rtp_pins_s  filt;
		rtp_pins_s  filt_d;
		logic [2:0] cnt_scl;
		logic [2:0] cnt_sda;
		rtp_state_e state;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic       ptr_done;
		logic       rd_dir;
		logic       hs;
		logic       hs_code;
		logic       commit;
		logic       sda_low;
		logic       rd_req;
		logic [7:0] tx_byte;
		rtp_req_s   buf0;
		rtp_req_s   buf1;
		logic [1:0] fill;
		rtp_req_s   req;
		logic       req_valid;
		logic       busy;
	} rtp_st_s;

	rtp_st_s st_reg;
	rtp_st_s st_next;

	function automatic logic [2:0] filt_step(input logic [2:0] cnt, input logic differ);
		filt_step = differ ? 3'(cnt + 3'h1) : 3'h0;
	endfunction

	// eight bits sampled: the byte is complete
	function automatic logic byte_end(input logic [3:0] bitn);
		byte_end = (bitn == 4'(RTP_BIT_LAST + 4'h1));
	endfunction

	function automatic logic [7:0] ptr_step(input logic [7:0] ptr);
		ptr_step = 8'(ptr + 8'h01);
	endfunction

	// start shifting out a read byte, msb first, and move the pointer on
	function automatic rtp_st_s load_tx(input rtp_st_s s, input logic [7:0] d);
		load_tx = s;
		load_tx.state = RTP_TX;
		load_tx.tx_byte = d;
		load_tx.ptr = ptr_step(s.ptr);
		load_tx.sda_low = ~d[7];
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [2:0] filt_len;
	rtp_req_s push_item;
	logic push;
	logic pop;

	always_comb begin
		st_next = st_reg;
		push = 1'b0;
		push_item = '0;
		// two-flop synchronisers on the pins
		st_next.sync1.scl = i_scl;
		st_next.sync1.sda = i_sda;
		st_next.sync2 = st_reg.sync1;
		// spike filters, length chosen by speed mode
		filt_len = st_reg.hs ? FILT_HS_LEN : FILT_LS_LEN;
		st_next.cnt_scl = filt_step(st_reg.cnt_scl, st_reg.sync2.scl != st_reg.filt.scl);
		st_next.cnt_sda = filt_step(st_reg.cnt_sda, st_reg.sync2.sda != st_reg.filt.sda);
		if (st_reg.cnt_scl >= filt_len) begin
			st_next.filt.scl = st_reg.sync2.scl;
			st_next.cnt_scl = 3'h0;
		end
		if (st_reg.cnt_sda >= filt_len) begin
			st_next.filt.sda = st_reg.sync2.sda;
			st_next.cnt_sda = 3'h0;
		end
		st_next.filt_d = st_reg.filt;
		// edges and bus conditions seen on the filtered lines
		scl_rise = st_reg.filt.scl & ~st_reg.filt_d.scl;
		scl_fall = ~st_reg.filt.scl & st_reg.filt_d.scl;
		start_c = st_reg.filt.scl & st_reg.filt_d.scl & st_reg.filt_d.sda & ~st_reg.filt.sda;
		stop_c = st_reg.filt.scl & st_reg.filt_d.scl & ~st_reg.filt_d.sda & st_reg.filt.sda;
		// read request is a one-cycle pulse
		st_next.rd_req = 1'b0;

		if (start_c) begin
			// repeated start treated as start; partial byte dropped
			st_next.state = RTP_ADDR;
			st_next.bitn = RTP_BIT_RESET;
			st_next.sda_low = 1'b0;
			st_next.commit = 1'b0;
		end else if (stop_c) begin
			st_next.state = RTP_IDLE;
			st_next.hs = 1'b0;
			st_next.sda_low = 1'b0;
			st_next.commit = 1'b0;
		end else if (scl_rise) begin
			// sample data while scl is high
			case (st_reg.state)
				RTP_ADDR, RTP_RX: begin
					st_next.shift = {st_reg.shift[6:0], st_reg.filt.sda};
					st_next.bitn = 4'(st_reg.bitn + 4'h1);
				end
				RTP_TX: st_next.bitn = 4'(st_reg.bitn + 4'h1);
				RTP_ACK_IN: begin
					if (st_reg.filt.sda)
						st_next.state = RTP_IDLE;
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st_reg.state)
				// address byte: acknowledge, take the high-speed code or ignore
				RTP_ADDR: begin
					if (byte_end(st_reg.bitn)) begin
						st_next.bitn = RTP_BIT_RESET;
						if (st_reg.shift[7:3] == RTP_HS_CODE_TOP) begin
							st_next.hs_code = 1'b1;
							st_next.state = RTP_IDLE;
						end else if (st_reg.shift[7:1] == TARGET_ADDR) begin
							st_next.state = RTP_ACK_OUT;
							st_next.sda_low = 1'b1;
							st_next.rd_dir = st_reg.shift[0];
							st_next.ptr_done = 1'b0;
							if (st_reg.shift[0])
								st_next.rd_req = 1'b1;
						end else begin
							st_next.state = RTP_IDLE;
						end
					end
				end
				// data byte: the first one is the pointer, later ones are committed
				RTP_RX: begin
					if (byte_end(st_reg.bitn)) begin
						st_next.bitn = RTP_BIT_RESET;
						st_next.state = RTP_ACK_OUT;
						st_next.sda_low = 1'b1;
						if (!st_reg.ptr_done) begin
							st_next.ptr = st_reg.shift;
							st_next.ptr_done = 1'b1;
						end else begin
							st_next.commit = 1'b1;
						end
					end
				end
				// end of the acknowledge clock
				RTP_ACK_OUT: begin
					st_next.sda_low = 1'b0;
					if (st_reg.commit) begin
						push = 1'b1;
						push_item = '{is_write: 1'b1, addr: st_reg.ptr, data: st_reg.shift};
						st_next.ptr = ptr_step(st_reg.ptr);
						st_next.commit = 1'b0;
					end
					if (st_reg.rd_dir)
						st_next = load_tx(st_next, i_rd_data);
					else
						st_next.state = RTP_RX;
				end
				// read data bits leave msb first
				RTP_TX: begin
					if (byte_end(st_reg.bitn)) begin
						st_next.bitn = RTP_BIT_RESET;
						st_next.state = RTP_ACK_IN;
						st_next.sda_low = 1'b0;
						st_next.rd_req = 1'b1;
					end else begin
						st_next.sda_low = ~st_reg.tx_byte[3'(RTP_BIT_LAST - st_reg.bitn)];
					end
				end
				// controller acknowledged: the next register goes out
				RTP_ACK_IN: begin
					st_next = load_tx(st_next, i_rd_data);
				end
				default: ;
			endcase
		end
		// fast filters only after the high-speed code and a restart
		if (st_reg.hs_code && start_c) begin
			st_next.hs = 1'b1;
			st_next.hs_code = 1'b0;
		end
		if (stop_c)
			st_next.hs_code = 1'b0;

		// read lookups go out as requests for the current pointer
		if (st_reg.rd_req) begin
			push = 1'b1;
			push_item = '{is_write: 1'b0, addr: st_reg.ptr, data: 8'h00};
		end

		// two-entry buffer toward the register store
		pop = st_reg.req_valid & i_req_ready;
		if (pop)
			st_next.req_valid = 1'b0;
		if (st_reg.fill != 2'h0 && (!st_reg.req_valid || pop)) begin
			st_next.req = st_reg.buf0;
			st_next.req_valid = 1'b1;
			st_next.buf0 = st_reg.buf1;
			st_next.fill = 2'(st_reg.fill - 2'h1);
		end
		if (push && st_next.fill != RTP_FIFO_DEPTH) begin
			if (st_next.fill == 2'h0)
				st_next.buf0 = push_item;
			else
				st_next.buf1 = push_item;
			st_next.fill = 2'(st_next.fill + 2'h1);
		end
		// busy leaves on a flip-flop like every other output that is not tied to a constant
		st_next.busy = (st_next.state != RTP_IDLE);
	end

	// lines come out of reset seen as released high
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '{sync1: '{1'b1, 1'b1}, sync2: '{1'b1, 1'b1}, filt: '{1'b1, 1'b1},
				filt_d: '{1'b1, 1'b1}, state: RTP_IDLE, ptr: RTP_PTR_RESET, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// scl is never driven; sda only pulled low
	assign o_scl_out = 1'b0;
	assign o_scl_oe = 1'b0;
	assign o_sda_out = 1'b0;
	assign o_sda_oe = st_reg.sda_low;
	assign o_req = st_reg.req;
	assign o_req_valid = st_reg.req_valid;
	assign o_hs_mode = st_reg.hs;
	assign o_busy = st_reg.busy;
endmodule

// ===== tb/rtp_ctl_model.sv
// rtp_ctl_model: behavioural bus controller, drives scl and shares sda
// assumes pull-ups, so a released line reads high
`timescale 1ns/1ns
module rtp_ctl_model (
	// clock and bus
	input  wire logic i_sys_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_rel
);
	int lo = 16;
	int hi = 8;
	initial begin
		o_scl = 1'b1;
		o_sda_rel = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	// one clock: sda set while low, second sda value mid-high, sampled there
	task automatic ph(input logic d1, input logic d2, input logic c2, output logic s);
		w(lo / 2);
		o_sda_rel <= d1;
		w(lo / 2);
		o_scl <= 1'b1;
		w(hi);
		s = i_sda;
		o_sda_rel <= d2;
		w(hi);
		o_scl <= c2;
	endtask
	task automatic start();
		logic s;
		ph(1'b1, 1'b0, 1'b0, s);
	endtask
	task automatic stop();
		logic s;
		ph(1'b0, 1'b1, 1'b1, s);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			ph(d[i], d[i], 1'b0, ack);
		end
		ph(1'b1, 1'b1, 1'b0, ack);
		ack = !ack;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic b;
		for (int i = 0; i < 8; i++) begin
			ph(1'b1, 1'b1, 1'b0, b);
			d = {d[6:0], b};
		end
		ph(!more, !more, 1'b0, b);
	endtask
endmodule

// ===== tb/rtp_target_sva.sv
// rtp_target_sva: port checks of the two-wire target
// assumes one clock domain; bound to every rtp_target
`timescale 1ns/1ns
module rtp_target_sva
	import rtp_pkg::*;
(
	// clock and reset
	input wire logic              i_sys_clk,
	input wire logic              i_rst,
	// pins
	input wire logic              i_scl,
	input wire logic              i_sda,
	input wire logic              o_sda_out,
	input wire logic              o_sda_oe,
	input wire logic              o_scl_oe,
	// outlet and status
	input wire rtp_pkg::rtp_req_s o_req,
	input wire logic              o_req_valid,
	input wire logic              i_req_ready,
	input wire logic              o_hs_mode,
	input wire logic              o_busy
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	property p_no_stretch; !o_scl_oe; endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("scl pulled low");
	property p_open_drain; o_sda_oe |-> !o_sda_out; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	property p_idle_free; !o_busy |-> !o_sda_oe; endproperty
	a_idle_free: assert property (p_idle_free) else $error("sda pulled while idle");
	property p_sda_steady; $changed(o_sda_oe) |-> !i_scl; endproperty
	a_sda_steady: assert property (p_sda_steady) else $error("sda moved with scl high");
	property p_ack_low; $rose(o_sda_oe) |=> !i_scl [*3]; endproperty
	a_ack_low: assert property (p_ack_low) else $error("ack pulled too late");
	property p_start_busy; $fell(i_sda) && i_scl |-> ##[1:16] o_busy; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start not seen");
	property p_stop_slow; $rose(i_sda) && i_scl |-> ##[1:16] !o_hs_mode; endproperty
	a_stop_slow: assert property (p_stop_slow) else $error("fast filters kept");
	property p_req_stand; o_req_valid && !i_req_ready |=> o_req_valid && $stable(o_req); endproperty
	a_req_stand: assert property (p_req_stand) else $error("request lost in stall");
endmodule
bind rtp_target rtp_target_sva u_sva (.i_sys_clk, .i_rst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe,
	.o_scl_oe, .o_req, .o_req_valid, .i_req_ready, .o_hs_mode, .o_busy);

// ===== tb/testbench.sv
// testbench: target driven through the controller model and a small store
// assumes rtp_pkg, rtp_target, the checker and the model compiled first
`timescale 1ns/1ns
module testbench;
	import rtp_pkg::*;
	logic       i_sys_clk, i_rst, i_req_ready, o_sda_out, o_sda_oe, o_scl_out, o_scl_oe;
	logic       o_req_valid, o_hs_mode, o_busy, c_scl, c_sda, ack;
	wire        i_scl = c_scl & ~(o_scl_oe & ~o_scl_out);
	wire        i_sda = c_sda & ~(o_sda_oe & ~o_sda_out);
	logic [7:0] i_rd_data = 8'h00;
	logic [7:0] got;
	logic [7:0] mem [256];
	logic [8:0] rows [5] = '{9'h141, 9'h143, 9'h000, 9'h010, 9'h148};
	rtp_req_s   o_req;
	int         err_total = 0;
	int         cmp_count = 0;
	int         nwr = 0;
	int         n0;
	rtp_target dut (.i_sys_clk, .i_rst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .o_scl_out, .o_scl_oe,
		.o_req, .o_req_valid, .i_req_ready, .i_rd_data, .o_hs_mode, .o_busy);
	rtp_ctl_model ctl (.i_sys_clk, .i_sda, .o_scl(c_scl), .o_sda_rel(c_sda));
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// register store behind the outlet
	always @(posedge i_sys_clk) begin
		if (o_req_valid && i_req_ready && o_req.is_write) begin
			mem[o_req.addr] <= o_req.data;
			nwr <= nwr + 1;
		end else if (o_req_valid && i_req_ready) begin
			i_rd_data <= mem[o_req.addr];
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		ctl.wbyte(d, ack);
		chk({7'h00, ack}, {7'h00, e});
	endtask
	task automatic stop_test();
		$display("counts: compares=%0d mismatches=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// tests need about 7500 cycles
	initial begin
		repeat (40000) @(posedge i_sys_clk);
		err_total++;
		stop_test();
	end
	initial begin
		foreach (mem[k]) mem[k] = 8'h00;
		i_rst = 1'b1;
		i_req_ready = 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (10) @(posedge i_sys_clk);
		chk({3'h0, o_scl_out, o_busy, o_sda_oe, o_hs_mode, o_scl_oe}, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			ctl.start();
			wb(rows[i][8:1], rows[i][0]);
			if (rows[i][1]) begin
				ctl.rbyte(1'b0, got);
				chk(got, 8'h00);
			end
			ctl.stop();
		end
		chk(8'(nwr), 8'h00);
		$display("address table test done");
		n0 = nwr;
		i_req_ready <= 1'b0;
		ctl.start();
		wb(8'hA0, 1'b1);
		wb(8'h02, 1'b1);
		wb(8'h11, 1'b1);
		wb(8'h22, 1'b1);
		ctl.stop();
		i_req_ready <= 1'b1;
		for (int k = 0; k < 50 && nwr < n0 + 2; k++) @(posedge i_sys_clk);
		chk(mem[2], 8'h11);
		chk(mem[3], 8'h22);
		ctl.start();
		wb(8'hA0, 1'b1);
		wb(8'h02, 1'b1);
		ctl.start();
		wb(8'hA1, 1'b1);
		ctl.rbyte(1'b1, got);
		chk(got, 8'h11);
		ctl.rbyte(1'b0, got);
		chk(got, 8'h22);
		ctl.stop();
		$display("burst test done");
		n0 = nwr;
		ctl.start();
		wb(8'hA0, 1'b1);
		wb(8'h05, 1'b1);
		for (int k = 0; k < 4; k++) ctl.ph(1'b1, 1'b1, 1'b0, ack);
		ctl.start();
		wb(8'hA0, 1'b1);
		ctl.stop();
		repeat (50) @(posedge i_sys_clk);
		chk(8'(nwr - n0), 8'h00);
		chk(mem[5], 8'h00);
		ctl.start();
		wb(8'h0D, 1'b0);
		ctl.hi = 6;
		ctl.start();
		wb(8'hA0, 1'b1);
		chk({7'h00, o_hs_mode}, 8'h01);
		wb(8'h07, 1'b1);
		wb(8'h33, 1'b1);
		ctl.stop();
		ctl.hi = 8;
		repeat (20) @(posedge i_sys_clk);
		chk({7'h00, o_hs_mode}, 8'h00);
		chk(mem[7], 8'h33);
		$display("abort and high speed tests done");
		ctl.start();
		wb(8'h0D, 1'b0);
		ctl.start();
		repeat (4) @(posedge i_sys_clk);
		chk({7'h00, o_hs_mode}, 8'h01);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (10) @(posedge i_sys_clk);
		chk({5'h00, o_busy, o_sda_oe, o_hs_mode}, 8'h00);
		ctl.stop();
		$display("mid-run reset test done");
		stop_test();
	end
endmodule
